//--- logic/mhc_cfg.svh
// constants for the maintenance hours counter
//
// What this block does
// - rising edge of lap_load clears expiry and reloads remaining hours
// - rising edge of full_clear clears expiry, zeroes total, reloads
// - service interval is whole hours, 0 to 9999
// - operating hours take a start offset, range 0 to 99999
// - expiry set at zero remaining, cleared while either reset is high
// - with idle_also_clears, a low monitor also clears expiry
// - time accrues and remaining counts down only while monitor is high
// - lap_load leaves the operating hours total untouched
// - total keeps counting while monitor high, whatever lap_load does
// - total saturates at 99999 hours, never wraps
// - start derives remaining as unused part of current interval
// - total, remaining and expiry survive power loss via restore
`ifndef MHC_CFG_SVH
`define MHC_CFG_SVH

// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define MHC_CLK_PERIOD_NS 10
`define MHC_HOUR_S        3600
`define MHC_HOUR_CYCLES   (64'd`MHC_HOUR_S * 64'd1000000000 / \
                           64'd`MHC_CLK_PERIOD_NS)

// ---------------------------------------------------------------------
// limits and reset values
// ---------------------------------------------------------------------
`define MHC_INTERVAL_MAX  14'd9999
`define MHC_HOURS_MAX     17'd99999
`define MHC_INTERVAL_RST  14'd9999
`define MHC_REMAIN_RST    14'd9999
`define MHC_HOURS_RST     17'd0
`define MHC_DIV_STEPS     5'd17

// ---------------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------------
`define MHC_OFF_CTRL      32'h0000_0000
`define MHC_OFF_INTERVAL  32'h0000_0004
`define MHC_OFF_HOURS     32'h0000_0008
`define MHC_OFF_REMAIN    32'h0000_000c
`define MHC_OFF_STATUS    32'h0000_0010

// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define MHC_CTRL_IDLE_BIT   0
`define MHC_CTRL_START_BIT  1
`define MHC_STAT_EXP_BIT    0
`define MHC_STAT_MON_BIT    1
`define MHC_STAT_BUSY_BIT   2
`define MHC_SYN_MON         0
`define MHC_SYN_LAP         1
`define MHC_SYN_FULL        2

`endif

//--- logic/mhc_pkg.sv
// types shared by the maintenance hours counter modules
package mhc_pkg;

   // register selected by a bus address
   typedef enum logic [2:0] {
      REG_CTRL,
      REG_INTERVAL,
      REG_HOURS,
      REG_REMAIN,
      REG_STATUS,
      REG_NONE
   } mhc_reg_e;

   // top level state
   typedef struct packed {
      logic [2:0]  sync1;
      logic [2:0]  sync2;
      logic [2:0]  prev;
      logic        idleClears;
      logic [13:0] interval;
      logic [13:0] remaining;
      logic [16:0] hours;
      logic        expiry;
      logic        startReq;
      logic        useResult;
      logic        pend;
      logic        pendWrite;
      logic [31:0] pendAddr;
      logic        hreadyout;
      logic        hresp;
      logic [31:0] hrdata;
   } mhc_top_s;

   // remainder calculator state
   typedef struct packed {
      logic        busy;
      logic        done;
      logic [4:0]  steps;
      logic [16:0] shift;
      logic [13:0] divisor;
      logic [14:0] rem;
   } mhc_div_s;

   // hour prescaler state
   typedef struct packed {
      logic [39:0] count;
      logic        tick;
   } mhc_tick_s;

endpackage : mhc_pkg

//--- logic/mhc_div_if.sv
// link between the counter core and its remainder calculator
`timescale 1ns/1ps
interface mhc_div_if;
   logic        start;
   logic [16:0] dividend;
   logic [13:0] divisor;
   logic        busy;
   logic        done;
   logic [13:0] remainder;

   modport req  (output start, dividend, divisor,
                 input  busy, done, remainder);
   modport calc (input  start, dividend, divisor,
                 output busy, done, remainder);
endinterface : mhc_div_if

//--- logic/mhc_hour_tick.sv
// prescaler that turns monitored on-time into one hour ticks
`timescale 1ns/1ps
`include "mhc_cfg.svh"
module mhc_hour_tick #(
   parameter logic [39:0] HOUR_CYCLES = 40'(`MHC_HOUR_CYCLES)
) (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic run,
   input  wire logic clear,
   output      logic tick
);
   mhc_pkg::mhc_tick_s s;
   mhc_pkg::mhc_tick_s next_s;

   // ------------------------------------------------------------------
   // counting
   // ------------------------------------------------------------------
   // fraction of the hour is kept while the monitor is low
   always_comb
   begin
      next_s = s;
      next_s.tick = 1'b0;
      if (clear)
      begin
         next_s.count = 40'h0;
      end
      else if (run)
      begin
         if (s.count >= HOUR_CYCLES - 40'h1)
         begin
            next_s.count = 40'h0;
            next_s.tick = 1'b1;
         end
         else
         begin
            next_s.count = s.count + 40'h1;
         end
      end
   end

   // state register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         s <= '0;
      else
         s <= next_s;
   end

   assign tick = s.tick;
endmodule : mhc_hour_tick

//--- logic/mhc_rem_calc.sv
// restoring remainder of operating hours by the service interval
`timescale 1ns/1ps
`include "mhc_cfg.svh"
module mhc_rem_calc (
   input  wire logic clk,
   input  wire logic rstn,
   mhc_div_if.calc   div
);
   mhc_pkg::mhc_div_s s;
   mhc_pkg::mhc_div_s next_s;
   logic [14:0]       trial;

   // ------------------------------------------------------------------
   // shift and subtract, one dividend bit per clock
   // ------------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      next_s.done = 1'b0;
      trial = {s.rem[13:0], s.shift[16]};
      if (s.busy)
      begin
         if (trial >= {1'b0, s.divisor})
            next_s.rem = trial - {1'b0, s.divisor};
         else
            next_s.rem = trial;
         next_s.shift = {s.shift[15:0], 1'b0};
         next_s.steps = s.steps - 5'd1;
         if (s.steps == 5'd1)
         begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
         end
      end
      else if (div.start)
      begin
         next_s.busy = 1'b1;
         next_s.steps = `MHC_DIV_STEPS;
         next_s.shift = div.dividend;
         next_s.divisor = div.divisor;
         next_s.rem = 15'h0;
      end
   end

   // state register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         s <= '0;
      else
         s <= next_s;
   end

   assign div.busy = s.busy;
   assign div.done = s.done;
   assign div.remainder = s.rem[13:0];
endmodule : mhc_rem_calc

//--- logic/mhc_hours_counter.sv
// operating hours and service interval counter with ahb-lite registers
`timescale 1ns/1ps
`include "mhc_cfg.svh"
module mhc_hours_counter #(
   parameter logic [39:0] HOUR_CYCLES = 40'(`MHC_HOUR_CYCLES)
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        monitor,
   input  wire logic        lapLoad,
   input  wire logic        fullClear,
   output      logic        expiry,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic        hreadyout,
   output      logic        hresp,
   output      logic [31:0] hrdata
);
   mhc_pkg::mhc_top_s s;
   mhc_pkg::mhc_top_s next_s;
   mhc_div_if         divLink ();
   logic              hourTick;
   logic              monitorOn;
   logic              lapRise;
   logic              fullRise;
   logic              resetHeld;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // map a byte address onto a register
   function automatic mhc_pkg::mhc_reg_e regOf(input logic [31:0] addr);
      mhc_pkg::mhc_reg_e r;
      r = mhc_pkg::REG_NONE;
      unique case (addr)
         `MHC_OFF_CTRL:     r = mhc_pkg::REG_CTRL;
         `MHC_OFF_INTERVAL: r = mhc_pkg::REG_INTERVAL;
         `MHC_OFF_HOURS:    r = mhc_pkg::REG_HOURS;
         `MHC_OFF_REMAIN:   r = mhc_pkg::REG_REMAIN;
         `MHC_OFF_STATUS:   r = mhc_pkg::REG_STATUS;
         default:           r = mhc_pkg::REG_NONE;
      endcase
      return r;
   endfunction : regOf

   // limit a written word to a 14 bit hour count
   function automatic logic [13:0] clampInterval(input logic [31:0] v);
      if (v > 32'(`MHC_INTERVAL_MAX))
         return `MHC_INTERVAL_MAX;
      else
         return v[13:0];
   endfunction : clampInterval

   // ------------------------------------------------------------------
   // submodules
   // ------------------------------------------------------------------
   // hour prescaler, runs only on monitored on-time
   mhc_hour_tick #(
      .HOUR_CYCLES (HOUR_CYCLES)
   ) u_tick (
      .clk   (clk),
      .rstn  (rstn),
      .run   (monitorOn),
      .clear (fullRise),
      .tick  (hourTick)
   );

   // remainder of hours by interval for the start calculation
   mhc_rem_calc u_rem (
      .clk  (clk),
      .rstn (rstn),
      .div  (divLink.calc)
   );

   assign divLink.start    = s.startReq;
   assign divLink.dividend = s.hours;
   assign divLink.divisor  = s.interval;

   // ------------------------------------------------------------------
   // synchronised inputs and edges
   // ------------------------------------------------------------------
   assign monitorOn = s.sync2[`MHC_SYN_MON];
   assign lapRise   = s.sync2[`MHC_SYN_LAP] & ~s.prev[`MHC_SYN_LAP];
   assign fullRise  = s.sync2[`MHC_SYN_FULL] & ~s.prev[`MHC_SYN_FULL];
   assign resetHeld = s.sync2[`MHC_SYN_LAP] | s.sync2[`MHC_SYN_FULL];

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      // two stage synchronisers, then an edge history stage
      next_s.sync1 = {fullClear, lapLoad, monitor};
      next_s.sync2 = s.sync1;
      next_s.prev = s.sync2;
      next_s.startReq = 1'b0;
      next_s.hreadyout = 1'b1;
      next_s.hresp = 1'b0;

      // bus: one wait state, then write or read data
      if (s.pend)
      begin
         next_s.pend = 1'b0;
         if (s.pendWrite)
         begin
            unique case (regOf(s.pendAddr))
               mhc_pkg::REG_CTRL:
               begin
                  next_s.idleClears = hwdata[`MHC_CTRL_IDLE_BIT];
                  if (hwdata[`MHC_CTRL_START_BIT] && !divLink.busy)
                  begin
                     next_s.startReq = 1'b1;
                     next_s.useResult = 1'b1;
                  end
               end
               mhc_pkg::REG_INTERVAL:
                  next_s.interval = clampInterval(hwdata);
               mhc_pkg::REG_HOURS:
                  if (hwdata > 32'(`MHC_HOURS_MAX))
                     next_s.hours = `MHC_HOURS_MAX;
                  else
                     next_s.hours = hwdata[16:0];
               mhc_pkg::REG_REMAIN:
                  next_s.remaining = clampInterval(hwdata);
               mhc_pkg::REG_STATUS:
                  next_s.expiry = hwdata[`MHC_STAT_EXP_BIT];
               mhc_pkg::REG_NONE:
                  next_s.pend = 1'b0;
            endcase
         end
         else
         begin
            unique case (regOf(s.pendAddr))
               mhc_pkg::REG_CTRL:
                  next_s.hrdata = {31'h0, s.idleClears};
               mhc_pkg::REG_INTERVAL:
                  next_s.hrdata = {18'h0, s.interval};
               mhc_pkg::REG_HOURS:
                  next_s.hrdata = {15'h0, s.hours};
               mhc_pkg::REG_REMAIN:
                  next_s.hrdata = {18'h0, s.remaining};
               mhc_pkg::REG_STATUS:
                  next_s.hrdata = {29'h0, divLink.busy, monitorOn,
                                   s.expiry};
               mhc_pkg::REG_NONE:
                  next_s.hrdata = 32'h0;
            endcase
         end
      end
      else if (hsel && htrans[1] && hready)
      begin
         next_s.pend = 1'b1;
         next_s.pendWrite = hwrite;
         next_s.pendAddr = haddr;
         next_s.hreadyout = 1'b0;
      end

      // hour tick while the monitor is high
      if (hourTick && monitorOn)
      begin
         if (next_s.hours < `MHC_HOURS_MAX)
            next_s.hours = next_s.hours + 17'd1;
         if (!divLink.busy && next_s.remaining != 14'd0)
            next_s.remaining = next_s.remaining - 14'd1;
      end

      // start: unused part of the current interval
      if (divLink.done && s.useResult)
      begin
         next_s.useResult = 1'b0;
         if (next_s.interval == 14'd0)
            next_s.remaining = 14'd0;
         else
            next_s.remaining = next_s.interval
                               - divLink.remainder;
      end

      // reset edges override the remaining count and start result above
      if (lapRise || fullRise)
      begin
         next_s.remaining = next_s.interval;
         next_s.useResult = 1'b0;
      end
      if (fullRise)
         next_s.hours = 17'd0;
      // lap_load alone never touches the total

      // expiry: clear terms win over the set term
      if (resetHeld || (s.idleClears && !monitorOn))
         next_s.expiry = 1'b0;
      else if (next_s.remaining == 14'd0)
         next_s.expiry = 1'b1;
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s <= '0;
         s.interval <= `MHC_INTERVAL_RST;
         s.remaining <= `MHC_REMAIN_RST;
         s.hours <= `MHC_HOURS_RST;
         s.hreadyout <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   // outputs straight from state
   assign expiry    = s.expiry;
   assign hreadyout = s.hreadyout;
   assign hresp     = s.hresp;
   assign hrdata    = s.hrdata;
endmodule : mhc_hours_counter

//--- bench/mhc_hours_counter_sva.sv
// assertions on the pins and bus of the hours counter
`timescale 1ns/1ps
module mhc_hours_counter_sva #(
   parameter logic [39:0] HOUR_CYCLES = 40'd20
) (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        lapLoad,
   input wire logic        fullClear,
   input wire logic        expiry,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata
);
   // ------------------------------------------------------------------
   // bus and pin checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // a transfer is taken when selected, active and ready
   logic taken;
   assign taken = hsel && htrans[1] && hready;

   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   chk_take_wait: assert property (taken |=> !hreadyout ##1 hreadyout)
      else $error("wait cycle missing after transfer");
   chk_wait_cause: assert property (!hreadyout |-> $past(taken))
      else $error("wait cycle without transfer");
   chk_wait_single: assert property (!hreadyout |=> hreadyout)
      else $error("wait longer than one cycle");
   chk_rdata_hold: assert property (!$rose(hreadyout) |-> $stable(hrdata))
      else $error("read data moved outside a read");
   chk_lap_clear: assert property (lapLoad [*6] |-> !expiry)
      else $error("expiry high while interval reset held");
   chk_full_clear: assert property (fullClear [*6] |-> !expiry)
      else $error("expiry high while full clear held");
   chk_clear_any: assert property ((lapLoad || fullClear) [*6] |-> !expiry)
      else $error("expiry high while a reset input held");

   // main scenarios reached
   cover property ($rose(expiry));
   cover property ($fell(expiry) && lapLoad);
   cover property (fullClear [*6]);
   cover property (taken ##2 taken);
endmodule : mhc_hours_counter_sva

bind mhc_hours_counter mhc_hours_counter_sva #(.HOUR_CYCLES(HOUR_CYCLES))
   chk_u (
      .clk       (clk),
      .rstn      (rstn),
      .lapLoad   (lapLoad),
      .fullClear (fullClear),
      .expiry    (expiry),
      .hsel      (hsel),
      .htrans    (htrans),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata)
   );

//--- bench/mhc_ctl_model.sv
// control logic model driving the monitored and reset pins
`timescale 1ns/1ps
module mhc_ctl_model (
   input  wire logic clk,
   output      logic monitor,
   output      logic lapLoad,
   output      logic fullClear
);
   // ------------------------------------------------------------------
   // pin drivers, all low at start so no edge is seen at reset release
   // ------------------------------------------------------------------
   initial
   begin
      monitor   = 1'b0;
      lapLoad   = 1'b0;
      fullClear = 1'b0;
   end

   // set monitor and lapLoad levels, then let the sync settle
   task automatic level(input logic m, input logic l);
      @(posedge clk);
      monitor <= m;
      lapLoad <= l;
      repeat (6) @(posedge clk);
   endtask : level

   // keep the monitor high for n clocks
   task automatic run(input int n);
      @(posedge clk);
      monitor <= 1'b1;
      repeat (n) @(posedge clk);
      monitor <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : run

   // six clock pulse on lapLoad or fullClear
   task automatic pulse(input logic full);
      @(posedge clk);
      if (full)
         fullClear <= 1'b1;
      else
         lapLoad <= 1'b1;
      repeat (6) @(posedge clk);
      fullClear <= 1'b0;
      lapLoad   <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : pulse
endmodule : mhc_ctl_model

//--- bench/test_maintenance_hours_counter.sv
// self-checking bench for the maintenance hours counter
`timescale 1ns/1ps
`include "mhc_cfg.svh"
module test_maintenance_hours_counter;
   // ------------------------------------------------------------------
   // signals, clock, design and pin model
   // ------------------------------------------------------------------
   logic        clk = 1'b0;
   logic        rstn, monitor, lapLoad, fullClear, expiry;
   logic        hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   int          errCount = 0;
   int          nTests = 0;

   always #5 clk = ~clk;
   assign hready = hreadyout; // single slave drives bus ready

   mhc_hours_counter #(.HOUR_CYCLES(40'd20)) dut_u (
      .clk       (clk),
      .rstn      (rstn),
      .monitor   (monitor),
      .lapLoad   (lapLoad),
      .fullClear (fullClear),
      .expiry    (expiry),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata)
   );
   mhc_ctl_model ctlU (
      .clk       (clk),
      .monitor   (monitor),
      .lapLoad   (lapLoad),
      .fullClear (fullClear)
   );

   // ------------------------------------------------------------------
   // bus tasks and comparison
   // ------------------------------------------------------------------
   task automatic check(input string n, input logic [31:0] s, e);
      nTests++;
      if (s !== e)
      begin
         errCount++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : check

   // address phase, then data phase, each held until ready
   task automatic busXfer(input logic w, input logic [31:0] a, d,
                          output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask : busXfer

   task automatic busWrite(input logic [31:0] a, d);
      logic [31:0] r;
      busXfer(1'b1, a, d, r);
   endtask : busWrite

   task automatic readCheck(input string n, input logic [31:0] a, e);
      logic [31:0] r;
      busXfer(1'b0, a, 32'h0000_0000, r);
      check(n, r, e);
   endtask : readCheck

   task automatic completeRun;
      $display("comparisons %0d mismatches %0d", nTests, errCount);
      if (errCount == 0 && nTests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : completeRun

   // ------------------------------------------------------------------
   // tests
   // ------------------------------------------------------------------
   initial
   begin
      rstn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      check("expiry", {31'd0, expiry}, 32'd0);
      readCheck("ctrl", `MHC_OFF_CTRL, 32'd0);
      readCheck("interval", `MHC_OFF_INTERVAL, 32'd9999);
      readCheck("hours", `MHC_OFF_HOURS, 32'd0);
      busWrite(32'h0000_0020, 32'hffff_ffff);
      readCheck("unmapped", 32'h0000_0020, 32'd0);
      busWrite(`MHC_OFF_INTERVAL, 32'd10000);
      readCheck("interval max", `MHC_OFF_INTERVAL, 32'd9999);
      busWrite(`MHC_OFF_HOURS, 32'd100000);
      readCheck("hours max", `MHC_OFF_HOURS, 32'd99999);
      $display("test reset and limits done");
      busWrite(`MHC_OFF_INTERVAL, 32'd100);
      busWrite(`MHC_OFF_HOURS, 32'd130);
      busWrite(`MHC_OFF_CTRL, 32'h0000_0002);
      repeat (30) @(posedge clk);
      readCheck("start remain", `MHC_OFF_REMAIN, 32'd70);
      $display("test start done");
      busWrite(`MHC_OFF_INTERVAL, 32'd5);
      ctlU.pulse(1'b1);
      readCheck("clear hours", `MHC_OFF_HOURS, 32'd0);
      readCheck("clear remain", `MHC_OFF_REMAIN, 32'd5);
      ctlU.run(70);
      readCheck("run hours", `MHC_OFF_HOURS, 32'd3);
      readCheck("run remain", `MHC_OFF_REMAIN, 32'd2);
      repeat (100) @(posedge clk);
      readCheck("idle hours", `MHC_OFF_HOURS, 32'd3);
      ctlU.level(1'b0, 1'b1);
      ctlU.run(40);
      ctlU.level(1'b0, 1'b0);
      readCheck("lap held hours", `MHC_OFF_HOURS, 32'd5);
      $display("test counting done");
      ctlU.pulse(1'b0);
      readCheck("lap remain", `MHC_OFF_REMAIN, 32'd5);
      ctlU.run(120);
      check("expiry set", {31'd0, expiry}, 32'd1);
      readCheck("held zero", `MHC_OFF_REMAIN, 32'd0);
      readCheck("total", `MHC_OFF_HOURS, 32'd11);
      busWrite(`MHC_OFF_CTRL, 32'h0000_0001);
      repeat (5) @(posedge clk);
      check("idle clear", {31'd0, expiry}, 32'd0);
      ctlU.level(1'b1, 1'b0);
      check("idle set", {31'd0, expiry}, 32'd1);
      ctlU.level(1'b0, 1'b0);
      busWrite(`MHC_OFF_CTRL, 32'h0000_0000);
      ctlU.pulse(1'b0);
      check("lap expiry", {31'd0, expiry}, 32'd0);
      readCheck("lap reload", `MHC_OFF_REMAIN, 32'd5);
      readCheck("lap total", `MHC_OFF_HOURS, 32'd11);
      ctlU.pulse(1'b1);
      readCheck("full total", `MHC_OFF_HOURS, 32'd0);
      $display("test expiry done");
      busWrite(`MHC_OFF_HOURS, 32'd99998);
      ctlU.run(70);
      readCheck("saturate", `MHC_OFF_HOURS, 32'd99999);
      busWrite(`MHC_OFF_REMAIN, 32'd7);
      readCheck("restore remain", `MHC_OFF_REMAIN, 32'd7);
      busWrite(`MHC_OFF_STATUS, 32'h0000_0001);
      readCheck("restore status", `MHC_OFF_STATUS, 32'd1);
      check("restore expiry", {31'd0, expiry}, 32'd1);
      $display("test saturate and restore done");
      rstn <= 1'b0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      check("reset expiry", {31'd0, expiry}, 32'd0);
      readCheck("reset remain", `MHC_OFF_REMAIN, 32'd9999);
      readCheck("reset hours", `MHC_OFF_HOURS, 32'd0);
      $display("test second reset done");
      completeRun();
   end

   // hang guard, well beyond the length of the tests
   initial
   begin
      repeat (6000) @(posedge clk);
      errCount++;
      completeRun();
   end
endmodule : test_maintenance_hours_counter
